// ==== rtl/ttio_port.v ====
// Byte-wide host I/O port for a 24-channel (8 isolated, 16 TTL) digital module.
// Assumes host bus strobes are already synchronous to clk; field inputs
// and jumper settings are asynchronous and are synchronised here.
`include "ttio_consts.vh"
`default_nettype none

module ttio_port #(
	parameter ADDR_W = 10
) (
	input wire clk,
	input wire rst_n,
	input wire [ADDR_W-1:0] bus_addr,
	input wire bus_aen,
	input wire bus_iow_n,
	input wire bus_ior_n,
	input wire [7:0] bus_wdata,
	output reg [7:0] bus_rdata,
	output reg bus_rdata_oe,
	input wire [7:0] base_select_switch,
	input wire [2:0] irq_line_jumper,
	input wire [1:0] irq_source_jumper,
	input wire irq_edge_jumper,
	input wire [7:0] isolated_input,
	input wire [15:0] ttl_input,
	output reg [7:0] isolated_output,
	output reg [15:0] ttl_output,
	output reg [4:0] irq_out
);

	// Three-stage synchronisers for asynchronous inputs
	reg [7:0] iso_s1_ff, iso_s2_ff, iso_s3_ff;
	reg [15:0] ttl_s1_ff, ttl_s2_ff, ttl_s3_ff;
	reg [13:0] cfg_s1_ff, cfg_s2_ff, cfg_s3_ff;
	reg [7:0] iso_ff;
	reg [15:0] ttl_ff;
	reg [13:0] cfg_ff;
	wire [13:0] cfg_raw;

	assign cfg_raw = {base_select_switch, irq_line_jumper,
		irq_source_jumper, irq_edge_jumper};

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			iso_s1_ff <= 8'h00;
			iso_s2_ff <= 8'h00;
			iso_s3_ff <= 8'h00;
			ttl_s1_ff <= 16'h0000;
			ttl_s2_ff <= 16'h0000;
			ttl_s3_ff <= 16'h0000;
			cfg_s1_ff <= 14'h0000;
			cfg_s2_ff <= 14'h0000;
			cfg_s3_ff <= 14'h0000;
		end else begin
			iso_s1_ff <= isolated_input;
			iso_s2_ff <= iso_s1_ff;
			iso_s3_ff <= iso_s2_ff;
			ttl_s1_ff <= ttl_input;
			ttl_s2_ff <= ttl_s1_ff;
			ttl_s3_ff <= ttl_s2_ff;
			cfg_s1_ff <= cfg_raw;
			cfg_s2_ff <= cfg_s1_ff;
			cfg_s3_ff <= cfg_s2_ff;
		end
	end

	// A bit changes only once stages two and three agree
	wire [7:0] nxt_iso;
	wire [15:0] nxt_ttl;
	wire [13:0] nxt_cfg;
	assign nxt_iso = (iso_s2_ff & iso_s3_ff) | (iso_ff & (iso_s2_ff | iso_s3_ff));
	assign nxt_ttl = (ttl_s2_ff & ttl_s3_ff) | (ttl_ff & (ttl_s2_ff | ttl_s3_ff));
	assign nxt_cfg = (cfg_s2_ff & cfg_s3_ff) | (cfg_ff & (cfg_s2_ff | cfg_s3_ff));

	// Edge detection waits until every synchroniser has filled after reset,
	// so a pin or jumper that is already high gives no false interrupt
	reg cfg_valid_ff;
	reg [2:0] settle_cnt_ff;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			iso_ff <= 8'h00;
			ttl_ff <= 16'h0000;
			cfg_ff <= 14'h0000;
			cfg_valid_ff <= 1'b0;
			settle_cnt_ff <= 3'h0;
		end else begin
			iso_ff <= nxt_iso;
			ttl_ff <= nxt_ttl;
			cfg_ff <= nxt_cfg;
			if (settle_cnt_ff != `TTIO_SETTLE_CYC)
				settle_cnt_ff <= settle_cnt_ff + 3'h1;
			cfg_valid_ff <= (settle_cnt_ff == `TTIO_SETTLE_CYC);
		end
	end

	wire [7:0] base_sel;
	wire [2:0] line_sel;
	wire [1:0] src_sel;
	wire edge_fall;
	assign base_sel = cfg_ff[13:6];
	assign line_sel = cfg_ff[5:3];
	assign src_sel = cfg_ff[2:1];
	assign edge_fall = cfg_ff[0];

	// Address decode: A9..A2 against switches, A1..A0 pick the byte
	wire hit;
	wire [1:0] ofs;
	assign hit = !bus_aen && (bus_addr[9:2] == base_sel);
	assign ofs = bus_addr[1:0];

	// Write strobe edge: latch on the falling edge of the write strobe
	reg iow_d_ff;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			iow_d_ff <= 1'b1;
		else
			iow_d_ff <= bus_iow_n;
	end
	wire wr_stb;
	assign wr_stb = hit && iow_d_ff && !bus_iow_n;

	// Output latches
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			isolated_output <= `TTIO_OUT_RST;
			ttl_output <= {`TTIO_OUT_RST, `TTIO_OUT_RST};
		end else if (wr_stb) begin
			case (ofs)
			`TTIO_OFS_ISO: isolated_output <= bus_wdata;
			`TTIO_OFS_TTL_LO: ttl_output[7:0] <= bus_wdata;
			`TTIO_OFS_TTL_HI: ttl_output[15:8] <= bus_wdata;
			default: ;
			endcase
		end
	end

	// Read data, driven from the clock after a decoded read starts until the clock after it ends
	reg [7:0] nxt_rdata;
	always @* begin
		case (ofs)
		`TTIO_OFS_ISO: nxt_rdata = iso_ff;
		`TTIO_OFS_TTL_LO: nxt_rdata = ttl_ff[7:0];
		`TTIO_OFS_TTL_HI: nxt_rdata = ttl_ff[15:8];
		default: nxt_rdata = `TTIO_UNUSED_RD;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= 8'h00;
			bus_rdata_oe <= 1'b0;
		end else begin
			bus_rdata <= nxt_rdata;
			bus_rdata_oe <= hit && !bus_ior_n;
		end
	end

	// Interrupt source, edge and line
	reg src_lvl;
	always @* begin
		case (src_sel)
		`TTIO_SRC_ISO0: src_lvl = iso_ff[0];
		`TTIO_SRC_ISO1: src_lvl = iso_ff[1];
		`TTIO_SRC_TTL0: src_lvl = ttl_ff[0];
		default: src_lvl = ttl_ff[1];
		endcase
	end

	reg src_d_ff;
	reg [3:0] pulse_cnt_ff;
	reg [3:0] nxt_pulse_cnt;
	wire trig;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			src_d_ff <= 1'b0;
		else
			src_d_ff <= src_lvl;
	end
	// Suppress a spurious edge while configuration settles after reset
	assign trig = cfg_valid_ff &&
		(edge_fall ? (src_d_ff && !src_lvl) : (!src_d_ff && src_lvl));

	always @* begin
		if (trig)
			nxt_pulse_cnt = `TTIO_IRQ_PULSE_CYC;
		else if (pulse_cnt_ff != 4'h0)
			nxt_pulse_cnt = pulse_cnt_ff - 4'h1;
		else
			nxt_pulse_cnt = 4'h0;
	end

	reg [4:0] nxt_irq;
	always @* begin
		nxt_irq = 5'h00;
		if (nxt_pulse_cnt != 4'h0) begin
			case (line_sel)
			`TTIO_IRQ2: nxt_irq = 5'h01;
			`TTIO_IRQ3: nxt_irq = 5'h02;
			`TTIO_IRQ5: nxt_irq = 5'h04;
			`TTIO_IRQ6: nxt_irq = 5'h08;
			`TTIO_IRQ7: nxt_irq = 5'h10;
			default: nxt_irq = 5'h00;
			endcase
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_cnt_ff <= 4'h0;
			irq_out <= 5'h00;
		end else begin
			pulse_cnt_ff <= nxt_pulse_cnt;
			irq_out <= nxt_irq;
		end
	end

endmodule // ttio_port

`default_nettype wire

// ==== rtl/ttio_consts.vh ====
// Constants for the isolated and TTL digital I/O port block.
// Assumes inclusion by bare name from the design file.
`ifndef TTIO_CONSTS_VH
`define TTIO_CONSTS_VH

// Register byte offsets from the card base
`define TTIO_OFS_ISO 2'h0
`define TTIO_OFS_UNUSED 2'h1
`define TTIO_OFS_TTL_LO 2'h2
`define TTIO_OFS_TTL_HI 2'h3

// Reset and fixed read values
`define TTIO_OUT_RST 8'h00
`define TTIO_UNUSED_RD 8'h00
`define TTIO_BASE_DEFAULT 8'hC0

// Interrupt source select codes
`define TTIO_SRC_ISO0 2'h0
`define TTIO_SRC_ISO1 2'h1
`define TTIO_SRC_TTL0 2'h2
`define TTIO_SRC_TTL1 2'h3

// Interrupt line select codes (one-hot outputs order: 2,3,5,6,7)
`define TTIO_IRQ_NONE 3'h0
`define TTIO_IRQ2 3'h1
`define TTIO_IRQ3 3'h2
`define TTIO_IRQ5 3'h3
`define TTIO_IRQ6 3'h4
`define TTIO_IRQ7 3'h5

// Interrupt pulse length in cycles
`define TTIO_IRQ_PULSE_CYC 4'h4

// Cycles after reset until synchronised inputs and jumpers are settled
`define TTIO_SETTLE_CYC 3'h5

`endif

// ==== sim/ttio_port_asserts.sv ====
// Checker for the digital I/O port host bus, latches and interrupt pulse.
// Assumes the base switches stay put while the host accesses the card.
`default_nettype none
module ttio_port_asserts #(
	parameter ADDR_W = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic bus_aen,
	input wire logic bus_iow_n,
	input wire logic bus_ior_n,
	input wire logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata,
	input wire logic bus_rdata_oe,
	input wire logic [7:0] base_select_switch,
	input wire logic [7:0] isolated_output,
	input wire logic [15:0] ttl_output,
	input wire logic [4:0] irq_out
);
	wire logic hit = !bus_aen && bus_addr[9:2] == base_select_switch;
	wire logic [1:0] ofs = bus_addr[1:0];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_WR_ISO: assert property ($fell(bus_iow_n) && hit && ofs == 2'h0
		|=> isolated_output == $past(bus_wdata)) else $error("iso write");
	AST_WR_TTL: assert property ($fell(bus_iow_n) && hit && ofs == 2'h2
		|=> ttl_output[7:0] == $past(bus_wdata)) else $error("ttl write");
	AST_HOLD: assert property (bus_iow_n || !hit || ofs == 2'h1
		|=> $stable({isolated_output, ttl_output})) else $error("latch moved");
	AST_RD_OE: assert property (!bus_ior_n && hit |=> bus_rdata_oe)
		else $error("no drive");
	AST_NO_OE: assert property (bus_ior_n || !hit |=> !bus_rdata_oe)
		else $error("stray drive");
	AST_RD_UNUSED: assert property (!bus_ior_n && hit && ofs == 2'h1
		|=> bus_rdata == 8'h00) else $error("unused read");
	AST_IRQ_ONE: assert property ($onehot0(irq_out))
		else $error("irq lines");
	AST_IRQ_LEN: assert property ($rose(irq_out != 5'h00)
		|-> (irq_out != 5'h00)[*4] ##1 irq_out == 5'h00) else $error("irq len");
endmodule // ttio_port_asserts
bind ttio_port ttio_port_asserts #(.ADDR_W(ADDR_W)) ttio_port_asserts_inst (
	.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_aen(bus_aen),
	.bus_iow_n(bus_iow_n), .bus_ior_n(bus_ior_n), .bus_wdata(bus_wdata),
	.bus_rdata(bus_rdata), .bus_rdata_oe(bus_rdata_oe),
	.base_select_switch(base_select_switch), .isolated_output(isolated_output),
	.ttl_output(ttl_output), .irq_out(irq_out));
`default_nettype wire

// ==== sim/ttio_host_model.sv ====
// Host side of the card bus: byte reads and writes by strobe.
// Assumes strobes are sampled on the rising edge of clk.
`default_nettype none
module ttio_host_model (
	input wire logic clk,
	output logic [9:0] bus_addr,
	output logic bus_aen,
	output logic bus_iow_n,
	output logic bus_ior_n,
	output logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata,
	input wire logic bus_rdata_oe
);
	initial begin
		bus_addr = 10'h000;
		bus_aen = 1'b0;
		bus_iow_n = 1'b1;
		bus_ior_n = 1'b1;
		bus_wdata = 8'h00;
	end
	// Released lines show the inverse of the last value
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_wdata = d;
		bus_iow_n = 1'b0;
		@(negedge clk);
		bus_iow_n = 1'b1;
		bus_addr = ~a;
		bus_wdata = ~d;
	endtask
	task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic o);
		@(negedge clk);
		bus_addr = a;
		bus_ior_n = 1'b0;
		repeat (2) @(negedge clk);
		d = bus_rdata;
		o = bus_rdata_oe;
		bus_ior_n = 1'b1;
		bus_addr = ~a;
	endtask
endmodule // ttio_host_model
`default_nettype wire

// ==== sim/tb_ttio_port.sv ====
// Bench for the digital I/O port: latches, reads and interrupt routing.
// Assumes the card base is fixed at 300 hex by the switches.
`default_nettype none
module tb_ttio_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, aen, iow_n, ior_n, oe, edg, o;
	logic [9:0] a;
	logic [7:0] wd, rd, iso, iso_o, d;
	logic [15:0] ttl, ttl_o;
	logic [15:0] ex [5];
	logic [2:0] line;
	logic [1:0] src;
	logic [4:0] irq;
	int error_cnt = 0, n_checks = 0;
	ttio_host_model ttio_host_model_inst (.clk(clk), .bus_addr(a),
		.bus_aen(aen), .bus_iow_n(iow_n), .bus_ior_n(ior_n), .bus_wdata(wd),
		.bus_rdata(rd), .bus_rdata_oe(oe));
	ttio_port ttio_port_inst (.clk(clk), .rst_n(rst_n), .bus_addr(a),
		.bus_aen(aen), .bus_iow_n(iow_n), .bus_ior_n(ior_n), .bus_wdata(wd),
		.bus_rdata(rd), .bus_rdata_oe(oe), .base_select_switch(8'hC0),
		.irq_line_jumper(line), .irq_source_jumper(src), .irq_edge_jumper(edg),
		.isolated_input(iso), .ttl_input(ttl), .isolated_output(iso_o),
		.ttl_output(ttl_o), .irq_out(irq));
	task automatic chk(input string n, input logic [15:0] e, g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic pin(input logic [1:0] s, input logic v);
		if (s[1]) ttl[s[0]] = v; else iso[s[0]] = v;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		error_cnt++;
		complete_run;
	end
	initial begin
		rst_n = 1'b0;
		line = 3'h0;
		src = 2'h0;
		edg = 1'b0;
		iso = 8'h00;
		ttl = 16'h0000;
		ex = '{16'h015A, 16'h0100, 16'h0134, 16'h0112, 16'h0000};
		repeat (12) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		repeat (6) @(negedge clk);
		chk("iso_o", 16'h0000, {8'h00, iso_o});
		chk("ttl_o", 16'h0000, ttl_o);
		$display("test reset done");
		ttio_host_model_inst.wr(10'h300, 8'hA5);
		ttio_host_model_inst.wr(10'h301, 8'hFF);
		ttio_host_model_inst.wr(10'h302, 8'h3C);
		ttio_host_model_inst.wr(10'h303, 8'hC3);
		ttio_host_model_inst.wr(10'h2FE, 8'h77);
		chk("iso_o", 16'h00A5, {8'h00, iso_o});
		chk("ttl_o", 16'hC33C, ttl_o);
		$display("test writes done");
		iso = 8'h5A;
		ttl = 16'h1234;
		repeat (6) @(negedge clk);
		for (int i = 0; i < 5; i++) begin
			ttio_host_model_inst.rd(10'(10'h300 + i), d, o);
			chk("read", ex[i], {7'h00, o, o ? d : 8'h00});
		end
		$display("test reads done");
		for (int i = 0; i < 5; i++) begin
			line = 3'(i + 1);
			src = 2'(i);
			edg = i[0];
			pin(src, edg);
			repeat (14) @(negedge clk);
			pin(src, !edg);
			for (int k = 0; k < 12 && irq === 5'h00; k++) @(negedge clk);
			chk("irq", 16'(1 << i), {11'h000, irq});
		end
		repeat (8) @(negedge clk);
		$display("test interrupt done");
		complete_run;
	end
endmodule // tb_ttio_port
`default_nettype wire
